// file: rtl/cms_defines.svh
// register map, field positions, reset values and timing of the control mode selector
`ifndef CMS_DEFINES_SVH
`define CMS_DEFINES_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define ADDR_CTRL 12'h000
`define ADDR_PERM 12'h004
`define ADDR_STATUS 12'h008
`define ADDR_DROPS 12'h00c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTRL_MENU_BIT 0
`define CTRL_FSEL_LSB 1
`define CTRL_FEN_BIT 3
`define REMOTE_BIT 5
`define PERM_AUTO_LSB 0
`define PERM_L1_LSB 8
`define PERM_L2_LSB 16

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CTRL_RST 4'h0
`define PERM_AUTO_RST 8'hab
`define PERM_L1_RST 8'hee
`define PERM_L2_RST 8'hee

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_HZ 40000000
`define SOL_TIMEOUT_MS 100
`define SOL_TIMEOUT_CYC (`SOL_TIMEOUT_MS * (`CLK_HZ / 1000))

`endif

// file: rtl/cms_pkg.sv
// types shared by the control mode selector modules
package cms_pkg;

  // binary codes of the operation modes; 2'b11 is illegal
  typedef enum logic [1:0]
  {
    MODE_LOCAL1 = 2'b00,
    MODE_LOCAL2 = 2'b01,
    MODE_AUTO = 2'b10
  } mode_t;

  // per mode: [0] start cyc [1] stop cyc [2] start panel [3] stop panel
  // [4] start acyc [5] stop acyc [6] start di [7] stop di
  typedef logic [7:0] perm_t;

endpackage

// file: rtl/mode_if.sv
// carrier between the selector and its mode arbiter
`timescale 1ns/1ps
`default_nettype none

interface mode_if;
  logic bus_fault;
  logic force_local;
  logic menu_open;
  logic remote_req;
  logic [23:0] perm_all;
  cms_pkg::mode_t mode;
  cms_pkg::perm_t perm;

  modport arbiter
  (
    input bus_fault, force_local, menu_open, remote_req, perm_all,
    output mode, perm
  );
  modport selector
  (
    output bus_fault, force_local, menu_open, remote_req, perm_all,
    input mode, perm
  );
endinterface

`default_nettype wire

// file: rtl/mode_arbiter.sv
// priority mode arbiter and permission set lookup
`timescale 1ns/1ps
`default_nettype none
`include "cms_defines.svh"

module mode_arbiter
(
  mode_if.arbiter port
);

  // fault first, then forced local, then panel menu, then remote bit
  always_comb
  begin
    if (port.bus_fault)
    begin
      port.mode = cms_pkg::MODE_LOCAL1;
    end
    else if (port.force_local)
    begin
      port.mode = cms_pkg::MODE_LOCAL2;
    end
    else if (port.menu_open)
    begin
      port.mode = cms_pkg::MODE_LOCAL1;
    end
    else if (port.remote_req)
    begin
      port.mode = cms_pkg::MODE_AUTO;
    end
    else
    begin
      port.mode = cms_pkg::MODE_LOCAL1;
    end
  end

  // each mode owns its own eight permission flags
  always_comb
  begin
    unique case (port.mode)
      cms_pkg::MODE_AUTO: port.perm = port.perm_all[`PERM_AUTO_LSB +: 8];
      cms_pkg::MODE_LOCAL1: port.perm = port.perm_all[`PERM_L1_LSB +: 8];
      cms_pkg::MODE_LOCAL2: port.perm = port.perm_all[`PERM_L2_LSB +: 8];
      default: port.perm = 8'h00;
    endcase
  end

endmodule

`default_nettype wire

// file: rtl/control_mode_selector.sv
// control mode selector: picks the operation mode and gates start/stop commands
//
// Behaviour
// - start and stop come from digital inputs, cyclic bus, panel, acyclic bus
// - every source has its own start and stop acceptance setting
// - three modes, remote, first local, second local, each with own permissions
// - the bus master asks for remote mode with the remote bit at one
// - by default remote mode starts only from cyclic telegrams
// - by default first local starts from digital inputs and panel
// - open panel motor menu enters first local and shows local control
// - force-local request enters second local, remote bit ignored
// - remote bit sits at bit 5 of telegram byte 0
// - missing bus master sign of life raises bus fault
// - priority: bus fault to first local, force-local, panel menu, then remote bit
// - exactly one mode is active at all times
// - nothing asserted and remote bit zero gives first local
// - force-local comes only from one configured multifunction input
// - command passes only when the active mode's flag allows it
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "cms_defines.svh"

module control_mode_selector
#(
  parameter int unsigned SOL_TIMEOUT_CYCLES = `SOL_TIMEOUT_CYC
)
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic telegram_valid_in,
  input wire logic [7:0] telegram_byte0_in,
  input wire logic [2:0] cmd_start_in,
  input wire logic [2:0] cmd_stop_in,
  input wire logic [2:0] multifunction_inputs_in,
  input wire logic di_start_pin_in,
  input wire logic di_stop_pin_in,
  output logic start_out,
  output logic stop_out,
  output logic motor_run_out,
  output logic [1:0] mode_out,
  output logic local_control_out,
  output logic bus_fault_out
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // per source mask; source 0 cyc, 1 panel, 2 acyc, 3 di
  function automatic logic [3:0] perm_mask(input cms_pkg::perm_t p, input logic stop);
    logic [3:0] m;
    m = 4'h0;
    for (int i = 0; i < 4; i++)
    begin
      m[i] = p[2 * i + int'(stop)];
    end
    return m;
  endfunction

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] r);
    return a == r;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [3:0] ctrl_q;
  logic [23:0] perm_q;
  logic [7:0] drops_q;
  logic [2:0] mfi_s1_q;
  logic [2:0] mfi_s2_q;
  logic [1:0] di_s1_q;
  logic [1:0] di_s2_q;
  logic [1:0] di_prev_q;
  logic force_local_q;
  logic remote_q;
  logic [23:0] sol_cnt_q;
  logic bus_fault_q;
  cms_pkg::mode_t mode_q;
  logic local_q;
  logic start_q;
  logic stop_q;
  logic run_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  logic access;
  logic wr_done;
  logic [3:0] start_req;
  logic [3:0] stop_req;
  logic [3:0] start_mask;
  logic [3:0] stop_mask;
  logic start_ok;
  logic stop_ok;
  logic dropped;
  logic force_sel;

  mode_if mif();

  mode_arbiter u_arbiter
  (
    .port(mif)
  );

  // ----------------------------------------------------------------
  // arbiter inputs
  // ----------------------------------------------------------------
  // all arbiter inputs are flops, so mode_q lags its cause by one edge
  assign mif.bus_fault = bus_fault_q;
  assign mif.force_local = force_local_q;
  assign mif.menu_open = ctrl_q[`CTRL_MENU_BIT];
  assign mif.remote_req = remote_q;
  assign mif.perm_all = perm_q;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // two flops before any logic looks at a pin
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      mfi_s1_q <= 3'h0;
      mfi_s2_q <= 3'h0;
      di_s1_q <= 2'h0;
      di_s2_q <= 2'h0;
      di_prev_q <= 2'h0;
    end
    else
    begin
      mfi_s1_q <= multifunction_inputs_in;
      mfi_s2_q <= mfi_s1_q;
      di_s1_q <= {di_stop_pin_in, di_start_pin_in};
      di_s2_q <= di_s1_q;
      di_prev_q <= di_s2_q;
    end
  end

  // select code 2'b11 names no input, so it never forces
  assign force_sel = (ctrl_q[`CTRL_FSEL_LSB +: 2] == 2'h3) ? 1'b0
    : mfi_s2_q[ctrl_q[`CTRL_FSEL_LSB +: 2]];

  // force-local from the one configured multifunction input
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      force_local_q <= 1'b0;
    end
    else
    begin
      force_local_q <= ctrl_q[`CTRL_FEN_BIT] & force_sel;
    end
  end

  // ----------------------------------------------------------------
  // bus master supervision
  // ----------------------------------------------------------------
  // remote bit latched from each cyclic telegram
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      remote_q <= 1'b0;
    end
    else if (telegram_valid_in)
    begin
      remote_q <= telegram_byte0_in[`REMOTE_BIT];
    end
  end

  // no telegram for the timeout means the master is gone; fault holds
  // from reset until the first telegram, so start-up is always local
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      sol_cnt_q <= 24'h000000;
      bus_fault_q <= 1'b1;
    end
    else if (telegram_valid_in)
    begin
      sol_cnt_q <= 24'h000000;
      bus_fault_q <= 1'b0;
    end
    else if (sol_cnt_q != 24'(SOL_TIMEOUT_CYCLES - 1))
    begin
      sol_cnt_q <= sol_cnt_q + 24'h000001;
    end
    else
    begin
      bus_fault_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // mode register
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      mode_q <= cms_pkg::MODE_LOCAL1;
      local_q <= 1'b1;
    end
    else
    begin
      mode_q <= mif.mode;
      local_q <= mif.mode != cms_pkg::MODE_AUTO;
    end
  end

  // ----------------------------------------------------------------
  // command gating
  // ----------------------------------------------------------------
  // digital start/stop act on the rising edge of the synced pin
  assign start_req = {di_s2_q[0] & ~di_prev_q[0], cmd_start_in};
  assign stop_req = {di_s2_q[1] & ~di_prev_q[1], cmd_stop_in};
  assign start_mask = perm_mask(mif.perm, 1'b0);
  assign stop_mask = perm_mask(mif.perm, 1'b1);
  assign start_ok = |(start_req & start_mask);
  assign stop_ok = |(stop_req & stop_mask);
  assign dropped = |(start_req & ~start_mask) | |(stop_req & ~stop_mask);

  // stop wins when both pass in one cycle
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      start_q <= 1'b0;
      stop_q <= 1'b0;
      run_q <= 1'b0;
    end
    else
    begin
      start_q <= start_ok;
      stop_q <= stop_ok;
      if (stop_ok)
      begin
        run_q <= 1'b0;
      end
      else if (start_ok)
      begin
        run_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  // one wait state: data is fetched while pready is low, so it is a flop
  assign access = psel_in & penable_in;
  assign wr_done = access & pready_q & pwrite_in;

  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
    else
    begin
      pready_q <= access & ~pready_q;
      if (access & ~pready_q)
      begin
        pslverr_q <= ~(addr_is(paddr_in, `ADDR_CTRL) | addr_is(paddr_in, `ADDR_PERM)
          | addr_is(paddr_in, `ADDR_STATUS) | addr_is(paddr_in, `ADDR_DROPS));
        if (addr_is(paddr_in, `ADDR_CTRL))
        begin
          prdata_q <= {28'h0000000, ctrl_q};
        end
        else if (addr_is(paddr_in, `ADDR_PERM))
        begin
          prdata_q <= {8'h00, perm_q};
        end
        else if (addr_is(paddr_in, `ADDR_STATUS))
        begin
          prdata_q <= {26'h0000000, run_q, remote_q, force_local_q, bus_fault_q, mode_q};
        end
        else if (addr_is(paddr_in, `ADDR_DROPS))
        begin
          prdata_q <= {24'h000000, drops_q};
        end
        else
        begin
          prdata_q <= 32'h00000000;
        end
      end
    end
  end

  // configuration writes take effect on the edge that completes the access
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      ctrl_q <= `CTRL_RST;
      perm_q <= {`PERM_L2_RST, `PERM_L1_RST, `PERM_AUTO_RST};
    end
    else if (wr_done & addr_is(paddr_in, `ADDR_CTRL))
    begin
      ctrl_q <= pwdata_in[3:0];
    end
    else if (wr_done & addr_is(paddr_in, `ADDR_PERM))
    begin
      perm_q <= pwdata_in[23:0];
    end
  end

  // drop counter saturates; a drop in the clearing cycle still counts
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      drops_q <= 8'h00;
    end
    else if (wr_done & addr_is(paddr_in, `ADDR_DROPS))
    begin
      drops_q <= {7'h00, dropped};
    end
    else if (dropped & (drops_q != 8'hff))
    begin
      drops_q <= drops_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign start_out = start_q;
  assign stop_out = stop_q;
  assign motor_run_out = run_q;
  assign mode_out = mode_q;
  assign local_control_out = local_q;
  assign bus_fault_out = bus_fault_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (reset_in);

  AST_FAULT_LOCAL1: assert property (bus_fault_q |=> mode_q == cms_pkg::MODE_LOCAL1)
    else $error("bus fault did not give first local mode");
  AST_FORCE_LOCAL2: assert property (!bus_fault_q && force_local_q
    |=> mode_q == cms_pkg::MODE_LOCAL2)
    else $error("force-local did not give second local mode");
  AST_REMOTE_AUTO: assert property (!bus_fault_q && !force_local_q && !ctrl_q[0] && remote_q
    |=> mode_q == cms_pkg::MODE_AUTO && !local_q)
    else $error("remote bit did not give remote mode");
  AST_IDLE_LOCAL1: assert property (!bus_fault_q && !force_local_q && !remote_q
    |=> mode_q == cms_pkg::MODE_LOCAL1 && local_q)
    else $error("idle inputs did not give first local mode");
  AST_ONE_MODE: assert property (mode_q != 2'b11)
    else $error("illegal mode code");
  AST_REMOTE_BIT: assert property (telegram_valid_in |=> remote_q == $past(telegram_byte0_in[5]))
    else $error("remote bit not taken from bit 5");
  AST_FAULT_TIMEOUT: assert property (sol_cnt_q == 24'(SOL_TIMEOUT_CYCLES - 1) && !telegram_valid_in
    |=> bus_fault_q)
    else $error("bus fault missing after timeout");
  AST_FORCE_SOURCE: assert property (force_local_q |-> $past(ctrl_q[3]))
    else $error("force-local without configured input");
  AST_START_PERMITTED: assert property (start_q |-> $past(start_ok))
    else $error("start passed without permission");
  AST_DROP_KEEPS_RUN: assert property (!start_ok && !stop_ok |=> run_q == $past(run_q))
    else $error("motor state changed without permitted command");
  AST_STOP_STOPS: assert property (stop_ok |=> !run_q && stop_q)
    else $error("permitted stop did not stop motor");

  COV_AUTO: cover property (mode_q == cms_pkg::MODE_AUTO ##1 start_q);
  COV_LOCAL2: cover property (mode_q == cms_pkg::MODE_LOCAL2 ##1 run_q);
  COV_DROP: cover property (dropped ##1 drops_q != 8'h00);

endmodule

`default_nettype wire

// file: verification/fieldbus_master_model.sv
// behavioural fieldbus master sending cyclic telegrams that carry the remote request
`timescale 1ns/1ps
`default_nettype none

module fieldbus_master_model
#(
  parameter int unsigned PERIOD = 5
)
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic active_in,
  input wire logic remote_in,
  output logic telegram_valid_out,
  output logic [7:0] telegram_byte0_out
);
  // ----------------------------------------------------------------
  // telegram pacing
  // ----------------------------------------------------------------
  int unsigned count_q;

  // one telegram per period while active; silence starves the sign of life
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      count_q <= 0;
      telegram_valid_out <= 1'b0;
      telegram_byte0_out <= 8'h00;
    end
    else if (active_in && count_q == PERIOD - 1)
    begin
      count_q <= 0;
      telegram_valid_out <= 1'b1;
      telegram_byte0_out <= {2'h0, remote_in, 5'h00}; // remote request in bit 5
    end
    else
    begin
      count_q <= (count_q >= PERIOD - 1) ? 0 : count_q + 1;
      telegram_valid_out <= 1'b0;
      telegram_byte0_out <= ~telegram_byte0_out; // stale byte toggles, never held
    end
  end
endmodule

`default_nettype wire

// file: verification/control_mode_selector_tb.sv
// self-checking bench for the control mode selector
`timescale 1ns/1ps
`default_nettype none
`include "cms_defines.svh"

module control_mode_selector_tb;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  localparam int unsigned SOL = 16;
  logic clock_in, reset_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd_data;
  logic telegram_valid_in, master_on, remote_in, rd_err;
  logic [7:0] telegram_byte0_in;
  logic [2:0] cmd_start_in, cmd_stop_in, multifunction_inputs_in;
  logic di_start_pin_in, di_stop_pin_in, start_out, stop_out, motor_run_out;
  logic local_control_out, bus_fault_out;
  logic [1:0] mode_out;
  int fails = 0;
  int samples_checked = 0;

  control_mode_selector #(.SOL_TIMEOUT_CYCLES(SOL)) u_dut
  (
    .clock_in(clock_in), .reset_in(reset_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .telegram_valid_in(telegram_valid_in), .telegram_byte0_in(telegram_byte0_in),
    .cmd_start_in(cmd_start_in), .cmd_stop_in(cmd_stop_in),
    .multifunction_inputs_in(multifunction_inputs_in), .di_start_pin_in(di_start_pin_in),
    .di_stop_pin_in(di_stop_pin_in), .start_out(start_out), .stop_out(stop_out),
    .motor_run_out(motor_run_out), .mode_out(mode_out),
    .local_control_out(local_control_out), .bus_fault_out(bus_fault_out)
  );

  fieldbus_master_model u_master
  (
    .clock_in(clock_in), .reset_in(reset_in), .active_in(master_on), .remote_in(remote_in),
    .telegram_valid_out(telegram_valid_in), .telegram_byte0_out(telegram_byte0_in)
  );

  // 40 MHz clock
  initial
  begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    if (fails == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
    int n;
    @(posedge clock_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= addr;
    pwdata_in <= wdata;
    @(posedge clock_in);
    penable_in <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clock_in);
      if (pready_out === 1'b1)
        break;
    end
    rd_data = prdata_out;
    rd_err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    if (n == 20)
    begin
      fails++;
      conclude();
    end
  endtask

  // settle on a mode within a bounded wait
  task automatic wait_mode(input logic [1:0] exp);
    int n;
    for (n = 0; n < 64; n++)
    begin
      @(posedge clock_in);
      #1;
      if (mode_out === exp)
        break;
    end
    check("mode_out", 32'(mode_out), 32'(exp));
    check("local_control_out", 32'(local_control_out), 32'(exp != 2'b10));
    if (n == 64)
    begin
      fails++;
      conclude();
    end
  endtask

  // src 0 cyclic, 1 panel, 2 acyclic, 3 digital input pin
  task automatic issue(input logic is_stop, input int src, input logic fire, input logic run);
    logic st;
    logic sp;
    st = 1'b0;
    sp = 1'b0;
    @(posedge clock_in);
    if (is_stop)
      {di_stop_pin_in, cmd_stop_in} <= 4'(1 << src);
    else
      {di_start_pin_in, cmd_start_in} <= 4'(1 << src);
    @(posedge clock_in);
    cmd_start_in <= 3'h0;
    cmd_stop_in <= 3'h0;
    // look from the launching edge on, a bus pulse stands only one cycle
    repeat (8)
    begin
      #1;
      st = st | start_out;
      sp = sp | stop_out;
      @(posedge clock_in);
    end
    di_start_pin_in <= 1'b0;
    di_stop_pin_in <= 1'b0;
    #1;
    check("start_out", 32'(st), 32'(fire & ~is_stop));
    check("stop_out", 32'(sp), 32'(fire & is_stop));
    check("motor_run_out", 32'(motor_run_out), 32'(run));
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_reset();
    @(posedge clock_in);
    #1;
    check("bus_fault_out", 32'(bus_fault_out), 32'h1);
    wait_mode(cms_pkg::MODE_LOCAL1);
    apb(1'b0, `ADDR_PERM, 32'h0);
    check("perm reset", rd_data, 32'h00eeeeab);
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped err", 32'(rd_err), 32'h1);
  endtask

  task automatic s_remote();
    @(posedge clock_in);
    master_on <= 1'b1;
    remote_in <= 1'b1;
    wait_mode(cms_pkg::MODE_AUTO);
    check("bus_fault_out", 32'(bus_fault_out), 32'h0);
    apb(1'b1, `ADDR_DROPS, 32'h0);
    issue(1'b0, 0, 1'b1, 1'b1);
    issue(1'b0, 1, 1'b0, 1'b1);
    issue(1'b0, 3, 1'b0, 1'b1);
    apb(1'b0, `ADDR_DROPS, 32'h0);
    check("drops", rd_data, 32'h2);
    issue(1'b1, 2, 1'b1, 1'b0);
  endtask

  // remote start from the cyclic bus withdrawn by software
  task automatic s_perm();
    apb(1'b1, `ADDR_PERM, 32'h00eeeeaa);
    issue(1'b0, 0, 1'b0, 1'b0);
    apb(1'b1, `ADDR_PERM, 32'h00eeeeab);
  endtask

  task automatic s_local();
    @(posedge clock_in);
    remote_in <= 1'b0;
    wait_mode(cms_pkg::MODE_LOCAL1);
    issue(1'b0, 0, 1'b0, 1'b0);
    issue(1'b0, 1, 1'b1, 1'b1);
    issue(1'b1, 3, 1'b1, 1'b0);
    issue(1'b0, 3, 1'b1, 1'b1);
    issue(1'b0, 2, 1'b0, 1'b1);
    issue(1'b1, 1, 1'b1, 1'b0);
  endtask

  task automatic s_menu();
    @(posedge clock_in);
    remote_in <= 1'b1;
    wait_mode(cms_pkg::MODE_AUTO);
    apb(1'b1, `ADDR_CTRL, 32'h1);
    wait_mode(cms_pkg::MODE_LOCAL1);
    apb(1'b1, `ADDR_CTRL, 32'h8);
    wait_mode(cms_pkg::MODE_AUTO);
  endtask

  // force-local wired to input 0 only; input 1 must not count
  task automatic s_force();
    @(posedge clock_in);
    multifunction_inputs_in <= 3'h2;
    repeat (8) @(posedge clock_in);
    #1;
    check("mode_out", 32'(mode_out), 32'h2);
    @(posedge clock_in);
    multifunction_inputs_in <= 3'h1;
    wait_mode(cms_pkg::MODE_LOCAL2);
    issue(1'b0, 0, 1'b0, 1'b0);
    issue(1'b0, 1, 1'b1, 1'b1);
  endtask

  task automatic s_fault();
    @(posedge clock_in);
    master_on <= 1'b0;
    wait_mode(cms_pkg::MODE_LOCAL1);
    check("bus_fault_out", 32'(bus_fault_out), 32'h1);
    @(posedge clock_in);
    master_on <= 1'b1;
    wait_mode(cms_pkg::MODE_LOCAL2);
  endtask

  // main sequence
  initial
  begin
    reset_in = 1'b1;
    {psel_in, penable_in, pwrite_in, master_on, remote_in} = 5'h00;
    {di_start_pin_in, di_stop_pin_in} = 2'h0;
    paddr_in = 12'h000;
    pwdata_in = 32'h00000000;
    {cmd_start_in, cmd_stop_in, multifunction_inputs_in} = 9'h000;
    repeat (2) @(posedge clock_in);
    reset_in <= 1'b0;
    s_reset();
    s_remote();
    s_perm();
    s_local();
    s_menu();
    s_force();
    s_fault();
    conclude();
  end
endmodule

`default_nettype wire
